// *** verilog/clksel_pkg.sv ***
// Package for the clock source selection block: register map, field positions, codes.
// Assumes an AXI4-Lite master with 32-bit data and one aligned word per register.
package clksel_pkg;
    localparam logic [3:0] ADDR_HF_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_LF_CTRL   = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STAT  = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK  = 4'hc;
    localparam int         HF_KEEP_RET    = 7;
    localparam int         HF_EXT_DIG     = 6;
    localparam int         HF_MODE_HI     = 5;
    localparam int         HF_MODE_LO     = 4;
    localparam int         HF_ON_XTAL     = 3;
    localparam int         LF_READY       = 6;
    localparam logic [7:0] HF_CTRL_RST    = 8'h00;
    localparam logic [2:0] LF_CTRL_RST    = 3'h1;
    localparam logic [1:0] HF_MODE_BOTH   = 2'h0;
    localparam logic [1:0] HF_MODE_RC     = 2'h1;
    localparam logic [1:0] HF_MODE_XTAL   = 2'h2;
    localparam logic [2:0] LF_SRC_XTAL    = 3'h0;
    localparam logic [2:0] LF_SRC_RC      = 3'h1;
    localparam logic [2:0] LF_SRC_SYNTH   = 3'h2;
    localparam logic [2:0] LF_SRC_EXT_ANA = 3'h3;
    localparam logic [2:0] LF_SRC_EXT_DIG = 3'h4;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;
    localparam int         SWITCH_GAP_CYC = 2;
    typedef enum logic [1:0] {
        CLKSEL_PWR_ACTIVE  = 2'h0,
        CLKSEL_PWR_STANDBY = 2'h1,
        CLKSEL_PWR_RETAIN  = 2'h2,
        CLKSEL_PWR_DEEP    = 2'h3
    } clksel_pwr_t;
    typedef enum logic [1:0] {
        CLKSEL_HF_RC   = 2'b00,
        CLKSEL_HF_GAP  = 2'b01,
        CLKSEL_HF_XTAL = 2'b11
    } clksel_hf_state_t;
    typedef struct packed {
        logic hf_rc_en;
        logic hf_xtal_en;
        logic lf_xtal_en;
        logic lf_rc_en;
        logic lf_synth_en;
        logic lf_ext_ana;
        logic lf_ext_dig;
    } clksel_osc_en_t;
endpackage

// *** verilog/clksel_top.sv ***
// Clock source selection: high- and low-frequency source control with AXI4-Lite registers.
// Assumes oscillator ready flags and the power mode come from outside this clock domain.
//
// Chosen here: the register offsets and the AXI4-Lite register port.
module clksel_top (
    // Clock and reset.
    input  wire logic                        mclk_i,
    input  wire logic                        rst_n_i,
    // AXI4-Lite slave.
    input  wire logic [3:0]                  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [3:0]                  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // Power mode and oscillator status from the analog side.
    input  wire clksel_pkg::clksel_pwr_t     pwr_mode_i,
    input  wire logic                        hf_xtal_stable_i,
    input  wire logic                        lf_osc_ready_i,
    // Oscillator enables and clock selects.
    output clksel_pkg::clksel_osc_en_t       osc_en_o,
    output logic                             hf_sel_xtal_o,
    output logic                             hf_sel_ext_o,
    output logic                             hf_gate_o,
    output logic                             lf_pins_xtal_o,
    // Interrupts.
    output logic                             misc_interrupt_request_o,
    output logic                             irq_o
);
    logic [7:0] hf_ctrl_r, hf_ctrl_nxt;
    logic [2:0] lf_ctrl_r, lf_ctrl_nxt;
    logic [1:0] irq_stat_r, irq_stat_nxt;
    logic [1:0] irq_mask_r, irq_mask_nxt;
    logic       aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt, bvalid_r, bvalid_nxt;
    logic [3:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic       rvalid_r, rvalid_nxt;
    logic [1:0] hs_s1_r, hs_s2_r, lfr_s1_r, lfr_s2_r, xs_r, xs_nxt;
    logic [1:0] pm_s1_r, pm_s2_r;
    logic       hf_ready_d_r, lf_ready_d_r;
    clksel_pkg::clksel_hf_state_t hf_st_r, hf_st_nxt;
    logic [1:0] gap_cnt_r, gap_cnt_nxt;
    clksel_pkg::clksel_osc_en_t en;
    logic       hf_xtal_ok, hf_rc_ok, hf_stable, lf_ready, xtal_run;
    logic [1:0] mode_s;

    // Check that a register address names one of the four register words.
    function automatic logic mapped(input logic [3:0] a);
        mapped = (a == clksel_pkg::ADDR_HF_CTRL) || (a == clksel_pkg::ADDR_LF_CTRL) ||
                 (a == clksel_pkg::ADDR_IRQ_STAT) || (a == clksel_pkg::ADDR_IRQ_MASK);
    endfunction

    // Two-stage synchronisers for the asynchronous status inputs.
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            hs_s1_r  <= 2'h0;
            hs_s2_r  <= 2'h0;
            lfr_s1_r <= 2'h0;
            lfr_s2_r <= 2'h0;
            pm_s1_r  <= 2'h0;
            pm_s2_r  <= 2'h0;
        end
        else
        begin
            hs_s1_r  <= {1'b0, hf_xtal_stable_i};
            hs_s2_r  <= hs_s1_r;
            lfr_s1_r <= {1'b0, lf_osc_ready_i};
            lfr_s2_r <= lfr_s1_r;
            pm_s1_r  <= pwr_mode_i;
            pm_s2_r  <= pm_s1_r;
        end
    end

    assign hf_stable = hs_s2_r[0];
    assign lf_ready  = lfr_s2_r[0];
    assign mode_s    = hf_ctrl_r[clksel_pkg::HF_MODE_HI:clksel_pkg::HF_MODE_LO];

    // Crystal runs in active and standby, and in retention when kept on.
    always_comb
    begin
        xtal_run = (pm_s2_r == clksel_pkg::CLKSEL_PWR_ACTIVE) || (pm_s2_r == clksel_pkg::CLKSEL_PWR_STANDBY) ||
                   ((pm_s2_r == clksel_pkg::CLKSEL_PWR_RETAIN) && hf_ctrl_r[clksel_pkg::HF_KEEP_RET]);
        hf_xtal_ok = xtal_run && (mode_s != clksel_pkg::HF_MODE_RC) && !hf_ctrl_r[clksel_pkg::HF_EXT_DIG];
        hf_rc_ok   = (mode_s != clksel_pkg::HF_MODE_XTAL) && !hf_ctrl_r[clksel_pkg::HF_EXT_DIG];
    end

    // HF source sequencer with a dead gap between sources.
    always_comb
    begin
        hf_st_nxt   = hf_st_r;
        gap_cnt_nxt = gap_cnt_r;
        case (hf_st_r)
            clksel_pkg::CLKSEL_HF_RC:
            begin
                if (hf_xtal_ok && hf_stable && mode_s != clksel_pkg::HF_MODE_RC)
                begin
                    hf_st_nxt   = clksel_pkg::CLKSEL_HF_GAP;
                    gap_cnt_nxt = 2'(clksel_pkg::SWITCH_GAP_CYC);
                end
            end
            clksel_pkg::CLKSEL_HF_GAP:
            begin
                if (gap_cnt_r != 2'h0)
                    gap_cnt_nxt = gap_cnt_r - 2'h1;
                else if (hf_xtal_ok && hf_stable)
                    hf_st_nxt = clksel_pkg::CLKSEL_HF_XTAL;
                else
                    hf_st_nxt = clksel_pkg::CLKSEL_HF_RC;
            end
            clksel_pkg::CLKSEL_HF_XTAL:
            begin
                if (!(hf_xtal_ok && hf_stable))
                begin
                    hf_st_nxt   = clksel_pkg::CLKSEL_HF_GAP;
                    gap_cnt_nxt = 2'(clksel_pkg::SWITCH_GAP_CYC);
                end
            end
            default:
                hf_st_nxt = clksel_pkg::CLKSEL_HF_RC;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            hf_st_r   <= clksel_pkg::CLKSEL_HF_RC;
            gap_cnt_r <= 2'h0;
        end
        else
        begin
            hf_st_r   <= hf_st_nxt;
            gap_cnt_r <= gap_cnt_nxt;
        end
    end

    // Oscillator enables.
    always_comb
    begin
        en.hf_xtal_en  = hf_xtal_ok;
        en.hf_rc_en    = hf_rc_ok && (hf_st_r != clksel_pkg::CLKSEL_HF_XTAL);
        en.lf_xtal_en  = (lf_ctrl_r == clksel_pkg::LF_SRC_XTAL) && (pm_s2_r != clksel_pkg::CLKSEL_PWR_DEEP);
        en.lf_rc_en    = (lf_ctrl_r == clksel_pkg::LF_SRC_RC);
        en.lf_synth_en = (lf_ctrl_r == clksel_pkg::LF_SRC_SYNTH) && hf_xtal_ok && hf_stable;
        en.lf_ext_ana  = (lf_ctrl_r == clksel_pkg::LF_SRC_EXT_ANA);
        en.lf_ext_dig  = (lf_ctrl_r == clksel_pkg::LF_SRC_EXT_DIG);
    end

    // LF ready: the synthesiser enable when the synthesiser is selected, else the synchronised ready flag.
    always_comb
    begin
        xs_nxt = {1'b0, (lf_ctrl_r == clksel_pkg::LF_SRC_SYNTH) ? en.lf_synth_en : lf_ready};
    end

    // Registered oscillator enables, source selects and ready edges.
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            osc_en_o       <= '0;
            hf_sel_xtal_o  <= 1'b0;
            hf_sel_ext_o   <= 1'b0;
            hf_gate_o      <= 1'b1;
            lf_pins_xtal_o <= 1'b0;
            xs_r           <= 2'h0;
            hf_ready_d_r   <= 1'b0;
            lf_ready_d_r   <= 1'b0;
        end
        else
        begin
            osc_en_o       <= en;
            hf_sel_xtal_o  <= (hf_st_r == clksel_pkg::CLKSEL_HF_XTAL);
            hf_sel_ext_o   <= hf_ctrl_r[clksel_pkg::HF_EXT_DIG];
            hf_gate_o      <= (hf_st_r != clksel_pkg::CLKSEL_HF_GAP);
            lf_pins_xtal_o <= (lf_ctrl_r == clksel_pkg::LF_SRC_XTAL);
            xs_r           <= xs_nxt;
            hf_ready_d_r   <= hf_xtal_ok && hf_stable;
            lf_ready_d_r   <= xs_nxt[0];
        end
    end

    // AXI4-Lite slave and register next values.
    always_comb
    begin
        hf_ctrl_nxt  = hf_ctrl_r;
        lf_ctrl_nxt  = lf_ctrl_r;
        irq_mask_nxt = irq_mask_r;
        aw_ok_nxt    = aw_ok_r;
        w_ok_nxt     = w_ok_r;
        awaddr_nxt   = awaddr_r;
        wdata_nxt    = wdata_r;
        wstrb_nxt    = wstrb_r;
        bvalid_nxt   = bvalid_r;
        bresp_nxt    = bresp_r;
        rvalid_nxt   = rvalid_r;
        rdata_nxt    = rdata_r;
        rresp_nxt    = rresp_r;
        irq_stat_nxt = irq_stat_r;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_ok_nxt  = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_ok_nxt  = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (aw_ok_r && w_ok_r && !bvalid_r)
        begin
            aw_ok_nxt  = 1'b0;
            w_ok_nxt   = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = mapped(awaddr_r) ? clksel_pkg::RESP_OKAY : clksel_pkg::RESP_SLVERR;
            if (wstrb_r[0])
            begin
                case (awaddr_r)
                    clksel_pkg::ADDR_HF_CTRL:
                        hf_ctrl_nxt = {wdata_r[7:4], 1'b0, wdata_r[2:0]};
                    clksel_pkg::ADDR_LF_CTRL:
                        lf_ctrl_nxt = wdata_r[2:0];
                    clksel_pkg::ADDR_IRQ_STAT:
                        irq_stat_nxt = irq_stat_r & ~wdata_r[1:0];
                    clksel_pkg::ADDR_IRQ_MASK:
                        irq_mask_nxt = wdata_r[1:0];
                    default:
                        hf_ctrl_nxt = hf_ctrl_r;
                endcase
            end
        end
        else if (bvalid_r && s_axi_bready)
            bvalid_nxt = 1'b0;
        // Events set after the clear so that a set wins.
        if ((hf_xtal_ok && hf_stable) && !hf_ready_d_r)
            irq_stat_nxt[0] = 1'b1;
        if (xs_nxt[0] && !lf_ready_d_r)
            irq_stat_nxt[1] = 1'b1;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = mapped(s_axi_araddr) ? clksel_pkg::RESP_OKAY : clksel_pkg::RESP_SLVERR;
            case (s_axi_araddr)
                clksel_pkg::ADDR_HF_CTRL:
                    rdata_nxt = {24'h0, hf_ctrl_r[7:4], (hf_st_r == clksel_pkg::CLKSEL_HF_XTAL),
                                 hf_ctrl_r[2:0]};
                clksel_pkg::ADDR_LF_CTRL:
                    rdata_nxt = {25'h0, xs_r[0], 3'h0, lf_ctrl_r};
                clksel_pkg::ADDR_IRQ_STAT:
                    rdata_nxt = {30'h0, irq_stat_r};
                clksel_pkg::ADDR_IRQ_MASK:
                    rdata_nxt = {30'h0, irq_mask_r};
                default:
                    rdata_nxt = 32'h0;
            endcase
        end
        else if (rvalid_r && s_axi_rready)
            rvalid_nxt = 1'b0;
    end

    // Register bank and bus state.
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            hf_ctrl_r  <= clksel_pkg::HF_CTRL_RST;
            lf_ctrl_r  <= clksel_pkg::LF_CTRL_RST;
            irq_stat_r <= 2'h0;
            irq_mask_r <= 2'h0;
            aw_ok_r    <= 1'b0;
            w_ok_r     <= 1'b0;
            awaddr_r   <= 4'h0;
            wdata_r    <= 32'h0;
            wstrb_r    <= 4'h0;
            bvalid_r   <= 1'b0;
            bresp_r    <= 2'h0;
            rvalid_r   <= 1'b0;
            rdata_r    <= 32'h0;
            rresp_r    <= 2'h0;
        end
        else
        begin
            hf_ctrl_r  <= hf_ctrl_nxt;
            lf_ctrl_r  <= lf_ctrl_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            aw_ok_r    <= aw_ok_nxt;
            w_ok_r     <= w_ok_nxt;
            awaddr_r   <= awaddr_nxt;
            wdata_r    <= wdata_nxt;
            wstrb_r    <= wstrb_nxt;
            bvalid_r   <= bvalid_nxt;
            bresp_r    <= bresp_nxt;
            rvalid_r   <= rvalid_nxt;
            rdata_r    <= rdata_nxt;
            rresp_r    <= rresp_nxt;
        end
    end

    assign s_axi_awready            = !aw_ok_r && !bvalid_r;
    assign s_axi_wready             = !w_ok_r && !bvalid_r;
    assign s_axi_bvalid             = bvalid_r;
    assign s_axi_bresp              = bresp_r;
    assign s_axi_arready            = !rvalid_r;
    assign s_axi_rvalid             = rvalid_r;
    assign s_axi_rdata              = rdata_r;
    assign s_axi_rresp              = rresp_r;
    assign misc_interrupt_request_o = irq_stat_r[0];
    assign irq_o                    = |(irq_stat_r & irq_mask_r);
endmodule

// *** verification/clksel_properties.sv ***
// Concurrent checks on the ports of the clock source selection block.
// Assumes it is bound to clksel_top and shares its clock and asynchronous active-low reset.
module clksel_properties (
    // Clock and reset.
    input wire logic                       mclk_i,
    input wire logic                       rst_n_i,
    // Register bus handshakes.
    input wire logic                       s_axi_awvalid,
    input wire logic                       s_axi_awready,
    input wire logic                       s_axi_wvalid,
    input wire logic                       s_axi_wready,
    input wire logic                       s_axi_bvalid,
    input wire logic                       s_axi_arvalid,
    input wire logic                       s_axi_arready,
    input wire logic [31:0]                s_axi_rdata,
    input wire logic [1:0]                 s_axi_rresp,
    input wire logic                       s_axi_rvalid,
    input wire logic                       s_axi_rready,
    // Status inputs.
    input wire clksel_pkg::clksel_pwr_t    pwr_mode_i,
    input wire logic                       hf_xtal_stable_i,
    // Clock control and interrupt outputs.
    input wire clksel_pkg::clksel_osc_en_t osc_en_o,
    input wire logic                       hf_sel_xtal_o,
    input wire logic                       hf_gate_o,
    input wire logic                       lf_pins_xtal_o,
    input wire logic                       misc_interrupt_request_o,
    input wire logic                       irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_gap_len: assert property ($fell(hf_gate_o) |-> !hf_gate_o [*3] ##1 hf_gate_o)
        else $error("Clock gap has the wrong length.");
    a_sel_in_gap: assert property ($changed(hf_sel_xtal_o) |-> !hf_gate_o || !$past(hf_gate_o))
        else $error("Clock source changed outside a gap.");
    a_rc_stops: assert property ($rose(hf_sel_xtal_o) |-> ##[0:2] !osc_en_o.hf_rc_en)
        else $error("RC oscillator kept running on crystal.");
    a_auto_switch: assert property ((osc_en_o.hf_xtal_en && hf_xtal_stable_i) [*8] |-> hf_sel_xtal_o)
        else $error("No switch to a stable crystal.");
    a_lf_pins: assert property (osc_en_o.lf_xtal_en |-> lf_pins_xtal_o)
        else $error("Crystal pins not claimed.");
    a_lf_single: assert property ($onehot0({osc_en_o.lf_xtal_en, osc_en_o.lf_rc_en, osc_en_o.lf_synth_en,
        osc_en_o.lf_ext_ana, osc_en_o.lf_ext_dig}))
        else $error("More than one low-frequency source.");
    a_deep_stop: assert property ((pwr_mode_i == clksel_pkg::CLKSEL_PWR_DEEP) [*4] |->
        !osc_en_o.hf_xtal_en && !osc_en_o.lf_xtal_en)
        else $error("Crystal running in deep sleep.");
    a_misc_raise: assert property ($rose(hf_xtal_stable_i) && osc_en_o.hf_xtal_en |->
        ##[1:5] misc_interrupt_request_o)
        else $error("Crystal ready did not raise the request.");
    a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |->
        ##[1:2] s_axi_bvalid)
        else $error("Write response late.");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read response late.");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("Read data not held.");

    c_switch: cover property ($rose(hf_sel_xtal_o));
    c_irq: cover property ($rose(irq_o));
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == clksel_pkg::RESP_SLVERR);
endmodule

bind clksel_top clksel_properties u_props (.mclk_i, .rst_n_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pwr_mode_i, .hf_xtal_stable_i, .osc_en_o, .hf_sel_xtal_o, .hf_gate_o, .lf_pins_xtal_o,
    .misc_interrupt_request_o, .irq_o);

// *** verification/testbench.sv ***
// Self-checking bench for the clock source selection block with seeded random register traffic.
// Assumes the package, the top module and the bound checker are compiled before it.
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                        mclk_i = 1'b0;
    logic                        rst_n_i = 1'b0;
    logic [3:0]                  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0]                 s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [1:0]                  s_axi_bresp, s_axi_rresp, rsp, pm;
    logic                        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic                        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic                        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    clksel_pkg::clksel_pwr_t     pwr_mode_i = clksel_pkg::CLKSEL_PWR_ACTIVE;
    logic                        hf_xtal_stable_i = 1'b0, lf_osc_ready_i = 1'b0, rdy;
    clksel_pkg::clksel_osc_en_t  osc_en_o, e;
    logic                        hf_sel_xtal_o, hf_sel_ext_o, hf_gate_o, lf_pins_xtal_o;
    logic                        misc_interrupt_request_o, irq_o;
    logic [7:0]                  hf;
    logic [2:0]                  lf;
    logic [12:0]                 corner [8] = '{{2'h0, 8'h00, 3'h0}, {2'h0, 8'h10, 3'h1}, {2'h0, 8'h20, 3'h2},
        {2'h0, 8'h30, 3'h3}, {2'h0, 8'h40, 3'h4}, {2'h2, 8'h80, 3'h2}, {2'h2, 8'h00, 3'h2}, {2'h3, 8'h00, 3'h0}};
    logic [31:0]                 rst_val [4] = '{32'h0, 32'h1, 32'h0, 32'h0};
    int                          error_cnt = 0, num_checks = 0;

    clksel_top DUT (.mclk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwr_mode_i, .hf_xtal_stable_i,
        .lf_osc_ready_i, .osc_en_o, .hf_sel_xtal_o, .hf_sel_ext_o, .hf_gate_o, .lf_pins_xtal_o,
        .misc_interrupt_request_o, .irq_o);

    initial
    begin
        forever #25 mclk_i = ~mclk_i;
    end

    task automatic end_of_test;
        $display("Checks %0d, errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Offers address and data together, holds each until taken, then waits for the response.
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge mclk_i);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic axi_rd(input logic [3:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge mclk_i);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge mclk_i);
    endtask

    // Expected enables once the crystal is stable and the selection has settled.
    function automatic clksel_pkg::clksel_osc_en_t exp_osc(input logic [1:0] p, input logic [7:0] h,
        input logic [2:0] l);
        clksel_pkg::clksel_osc_en_t x;
        x = '0;
        x.hf_xtal_en = h[5:4] != clksel_pkg::HF_MODE_RC && !h[6] && (p < 2'h2 || (p == 2'h2 && h[7]));
        x.hf_rc_en = !x.hf_xtal_en && h[5:4] != clksel_pkg::HF_MODE_XTAL && !h[6];
        x.lf_xtal_en = l == clksel_pkg::LF_SRC_XTAL && p != 2'h3;
        x.lf_rc_en = l == clksel_pkg::LF_SRC_RC;
        x.lf_synth_en = l == clksel_pkg::LF_SRC_SYNTH && x.hf_xtal_en;
        x.lf_ext_ana = l == clksel_pkg::LF_SRC_EXT_ANA;
        x.lf_ext_dig = l == clksel_pkg::LF_SRC_EXT_DIG;
        return x;
    endfunction

    initial
    begin
        repeat (20000) @(posedge mclk_i);
        $display("ERROR t=%0t watchdog expired", $time);
        error_cnt++;
        end_of_test;
    end

    initial
    begin
        void'($urandom(40));
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        for (int i = 0; i < 4; i++)
        begin
            axi_rd(4'(4 * i));
            `CHK(rd, rst_val[i]);
        end
        `CHK({osc_en_o.hf_rc_en, osc_en_o.hf_xtal_en, hf_sel_xtal_o}, 3'b110);
        axi_rd(4'h2);
        `CHK({rsp, rd}, {clksel_pkg::RESP_SLVERR, 32'h0});
        axi_wr(4'h2, 32'hff);
        `CHK(rsp, clksel_pkg::RESP_SLVERR);
        hf_xtal_stable_i <= 1'b1;
        lf_osc_ready_i <= 1'b1;
        repeat (16) @(posedge mclk_i);
        `CHK({osc_en_o.hf_rc_en, hf_sel_xtal_o, misc_interrupt_request_o, irq_o}, 4'b0110);
        axi_wr(clksel_pkg::ADDR_IRQ_MASK, 32'h1);
        `CHK(irq_o, 1'b1);
        axi_wr(clksel_pkg::ADDR_IRQ_STAT, 32'h1);
        `CHK({misc_interrupt_request_o, irq_o}, 2'b00);
        axi_wr(clksel_pkg::ADDR_IRQ_MASK, 32'h2);
        `CHK(irq_o, 1'b1);
        axi_wr(clksel_pkg::ADDR_IRQ_STAT, 32'h2);
        `CHK(irq_o, 1'b0);
        for (int i = 0; i < 48; i++)
        begin
            {pm, hf, lf} = (i < 8) ? corner[i] : {2'($urandom), 8'($urandom), 3'($urandom_range(4))};
            rdy = 1'($urandom);
            pwr_mode_i <= clksel_pkg::clksel_pwr_t'(pm);
            lf_osc_ready_i <= rdy;
            axi_wr(clksel_pkg::ADDR_HF_CTRL, {24'h0, hf});
            `CHK(rsp, clksel_pkg::RESP_OKAY);
            axi_wr(clksel_pkg::ADDR_LF_CTRL, {29'h0, lf});
            repeat (16) @(posedge mclk_i);
            e = exp_osc(pm, hf, lf);
            `CHK(osc_en_o, e);
            `CHK({hf_sel_xtal_o, hf_sel_ext_o, lf_pins_xtal_o}, {e.hf_xtal_en, hf[6], lf == 3'h0});
            axi_rd(clksel_pkg::ADDR_HF_CTRL);
            `CHK(rd, {24'h0, hf[7:4], e.hf_xtal_en, hf[2:0]});
            axi_rd(clksel_pkg::ADDR_LF_CTRL);
            `CHK(rd, {25'h0, (lf == clksel_pkg::LF_SRC_SYNTH) ? e.lf_synth_en : rdy, 3'h0, lf});
        end
        end_of_test;
    end
endmodule
